// file: hw/tcsi_channel_if.sv
`default_nettype none
// How it works
// - five 6-bit characters, first one most significant
// - search compares block first word, reads match
// - status word on abnormal end or interrupt completion
// - code in bits 29..24, rest zero
// - external interrupt pulses with each status word
// - code 34: bad function, unit select, 00
// - code 54: tape mark or write echo error
// - code 50: processor too slow with acknowledge
// - code 44: parity error or write-check miscompare
// - code 70: block frames not multiple of five
// - code 60: load point or end warning
// - code 30: character counter holds improper count
// - code 20: end of block, partial word
// - code 40: interrupt function finished cleanly
// - read and write only moving forward
module tcsi_channel_if
   import tcsi_pkg::*;
#(
   parameter int UNITS_P = UNITS
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic fn_valid_i,
   input wire logic [11:0] fn_code_i,
   input wire logic [UNITS_P-1:0] unit_sel_i,
   input wire logic ext_fn_i,
   input wire logic [WORD_W-1:0] out_word_i,
   input wire logic out_ack_i,
   input wire logic in_ack_i,
   input wire logic eob_i,
   input wire logic [UNITS_P-1:0] unit_present_i,
   input wire logic [UNITS_P-1:0] unit_ring_i,
   input wire logic [UNITS_P-1:0] unit_ilk_i,
   input wire logic [UNITS_P-1:0] unit_rewinding_i,
   input wire tcsi_tape_ev_t ev_i,
   output logic [WORD_W-1:0] status_word_o,
   output logic ext_int_o,
   output logic [WORD_W-1:0] in_word_o,
   output logic in_req_o,
   output logic out_req_o,
   output logic [CHAR_W-1:0] wr_char_o,
   output logic wr_char_valid_o,
   output logic [UNITS_P-1:0] unit_o,
   output tcsi_op_t op_o,
   output logic run_o,
   output logic fwd_o
);
   tcsi_state_t state, next_state;
   tcsi_dec_t dec;
   logic irq, found, first_word, eob_seen, sent_any, done, wfull;
   logic [WORD_W-1:0] ident, wbuf;
   logic [2:0] wchar, pk_cnt;
   logic [NERR-1:0] err, next_err;
   logic [WORD_W-1:0] pk_word;
   logic pk_valid, onehot, fn_take, fn_err, ilk_err, rew_err, term_take;
   logic rd_mode, wr_mode, fwd_word, rd_busy, pk_clr;

   // function word checks, done combinationally at the take
   assign dec = tcsi_decode(fn_code_i);
   assign onehot = (unit_sel_i != '0) && ((unit_sel_i & (unit_sel_i - 1'b1)) == '0);
   assign fn_take = fn_valid_i && (state == ST_IDLE);
   assign fn_err = !dec.valid || !onehot;
   assign ilk_err = !(|(unit_sel_i & unit_present_i)) || |(unit_sel_i & unit_ilk_i)
                    || (dec.op == OP_WRITE && !(|(unit_sel_i & unit_ring_i)));
   assign rew_err = |(unit_sel_i & unit_rewinding_i);
   assign term_take = fn_valid_i && (state == ST_RUN) && dec.valid && dec.op == OP_TERM;

   // data moves only while tape goes forward
   assign rd_mode = (state == ST_RUN) && fwd_o
                    && (op_o inside {OP_READ, OP_SEARCH, OP_BOOT});
   assign wr_mode = (state == ST_RUN) && fwd_o && (op_o == OP_WRITE);
   assign fwd_word = pk_valid && rd_mode && (op_o != OP_SEARCH || found
                     || (first_word && pk_word == ident));
   assign rd_busy = in_req_o && !in_ack_i;
   assign pk_clr = fn_take || (rd_mode && ev_i.block_end);

   tcsi_char_pack #(.CHAR_W(CHAR_W), .CHARS(CHARS), .CNT_W(3)) u_pack (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .clr_i(pk_clr),
      .ch_valid_i(rd_mode && ev_i.frame_valid),
      .ch_i(ev_i.frame),
      .word_o(pk_word),
      .word_valid_o(pk_valid),
      .cnt_o(pk_cnt)
   );

   // sequencing: a bad function goes straight to the report
   always_comb begin
      next_state = state;
      unique case (state)
         ST_IDLE: begin
            if (fn_take) begin
               if (fn_err || ilk_err || rew_err || dec.op == OP_TERM) next_state = ST_REPORT;
               else if (dec.op == OP_SEARCH) next_state = ST_IDENT;
               else next_state = ST_RUN;
            end
         end
         ST_IDENT: if (ext_fn_i) next_state = ST_RUN;
         ST_RUN: if (done || |(err & ~ERR_DEFER)) next_state = ST_REPORT;
         ST_REPORT: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state <= ST_IDLE;
         run_o <= 1'b0;
         fwd_o <= 1'b0;
      end else begin
         state <= next_state;
         run_o <= (next_state == ST_RUN);
         fwd_o <= (next_state == ST_RUN) && tcsi_fwd(fn_take ? dec.op : op_o);
      end
   end

   // command latch and identifier capture
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         op_o <= OP_READ;
         irq <= 1'b0;
         unit_o <= '0;
         ident <= '0;
      end else begin
         if (fn_take) begin
            op_o <= dec.op;
            irq <= dec.irq;
            unit_o <= unit_sel_i;
         end
         if (state == ST_IDENT && ext_fn_i) ident <= out_word_i;
      end
   end

   // error collection; anything seen in one function ends up in one word
   always_comb begin
      next_err = err;
      if (fn_take) begin
         next_err = ERR_NONE;
         next_err[E_FN] = fn_err;
         next_err[E_ILK] = !fn_err && ilk_err;
         next_err[E_REW] = !fn_err && rew_err;
      end
      if (state == ST_RUN) begin
         if (rd_mode && ev_i.tape_mark) next_err[E_EOF] = 1'b1;
         if (wr_mode && ev_i.echo_err && sent_any) next_err[E_EOF] = 1'b1;
         if (fwd_word && rd_busy) next_err[E_SEQ] = 1'b1;
         if (wr_mode && ev_i.wr_slot && !wfull && !eob_seen) next_err[E_SEQ] = 1'b1;
         if (rd_mode && ev_i.frame_valid && ev_i.par_err) next_err[E_PAR] = 1'b1;
         if (wr_mode && ev_i.cmp_err) next_err[E_PAR] = 1'b1;
         if (rd_mode && ev_i.block_end && pk_cnt != 3'h0) next_err[E_FCNT] = 1'b1;
         if (ev_i.limit && tcsi_lim(op_o)) next_err[E_LIM] = 1'b1;
         if (ev_i.cc_err) next_err[E_CCNT] = 1'b1;
         if (eob_i && ((rd_mode && pk_cnt != 3'h0) || (wr_mode && wfull))) begin
            next_err[E_CSEQ] = 1'b1;
         end
         if (wr_mode && ev_i.wr_slot && wfull && !sent_any && wbuf[29:24] == 6'h00) begin
            next_err[E_FN] = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) err <= ERR_NONE;
      else if (state == ST_REPORT) err <= ERR_NONE;
      else err <= next_err;
   end

   // completion of the running function
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         done <= 1'b0;
         found <= 1'b0;
         first_word <= 1'b1;
      end else if (fn_take) begin
         done <= 1'b0;
         found <= 1'b0;
         first_word <= 1'b1;
      end else if (state == ST_RUN) begin
         if (pk_valid && rd_mode) first_word <= 1'b0;
         if (fwd_word) found <= 1'b1;
         if (rd_mode && ev_i.block_end) begin
            // a search without a hit keeps hunting, terminate stops it
            if (op_o != OP_SEARCH || found || fwd_word || term_take) done <= 1'b1;
            first_word <= 1'b1;
         end
         if (!rd_mode && !wr_mode && ev_i.done) done <= 1'b1;
         if (wr_mode && ev_i.done && eob_seen) done <= 1'b1;
      end else begin
         done <= 1'b0;
      end
   end

   // input words to the processor; an acknowledge frees the register
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         in_word_o <= '0;
         in_req_o <= 1'b0;
      end else if (fwd_word && !rd_busy) begin
         in_word_o <= pk_word;
         in_req_o <= 1'b1;
      end else if (in_ack_i) begin
         in_req_o <= 1'b0;
      end
   end

   // output words, split into characters first character first
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wbuf <= '0;
         wfull <= 1'b0;
         wchar <= 3'h0;
         sent_any <= 1'b0;
         eob_seen <= 1'b0;
         out_req_o <= 1'b0;
         wr_char_o <= '0;
         wr_char_valid_o <= 1'b0;
      end else begin
         wr_char_valid_o <= 1'b0;
         if (fn_take) begin
            wfull <= 1'b0;
            wchar <= 3'h0;
            sent_any <= 1'b0;
            eob_seen <= 1'b0;
         end else if (wr_mode) begin
            if (eob_i) eob_seen <= 1'b1;
            if (out_ack_i && out_req_o) begin
               wbuf <= out_word_i;
               wfull <= 1'b1;
               wchar <= 3'h0;
            end else if (ev_i.wr_slot && wfull) begin
               wr_char_o <= wbuf[29:24];
               wr_char_valid_o <= 1'b1;
               wbuf <= {wbuf[23:0], 6'h00};
               sent_any <= 1'b1;
               wchar <= wchar + 3'h1;
               if (wchar == 3'(CHARS - 1)) wfull <= 1'b0;
            end
         end
         // one word is asked for only when the register has room
         out_req_o <= wr_mode && !eob_seen && !eob_i && !(out_ack_i && out_req_o)
                      && (!wfull || (ev_i.wr_slot && wchar == 3'(CHARS - 1)));
      end
   end

   // status word: one code, picked by priority
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         status_word_o <= '0;
         ext_int_o <= 1'b0;
      end else begin
         ext_int_o <= 1'b0;
         if (state == ST_REPORT && (err != ERR_NONE || irq)) begin
            status_word_o <= {tcsi_pick(err), 24'h000000};
            ext_int_o <= 1'b1;
         end
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);

   sequence s_status(logic [5:0] c);
      ext_int_o && status_word_o[29:24] == c;
   endsequence

   sequence s_clean_take;
      fn_take && dec.valid && onehot && !ilk_err && dec.op != OP_TERM;
   endsequence

   a_unused_bits: assert property (status_word_o[23:0] == 24'h000000)
      else $error("status word low bits not zero");
   a_int_single: assert property (ext_int_o |=> !ext_int_o)
      else $error("interrupt held longer than one cycle");
   a_report_word: assert property (state == ST_REPORT && err != ERR_NONE |=> ext_int_o)
      else $error("abnormal end gave no status word");
   a_bad_fn_code: assert property (fn_take && !dec.valid |-> ##2 s_status(SC_FN))
      else $error("invalid function not reported as 34");
   a_rewind_code: assert property (s_clean_take and rew_err |-> ##2 s_status(SC_REW))
      else $error("rewinding unit not reported as 24");
   a_read_overrun: assert property (state == ST_RUN && fwd_word && rd_busy |=> err[E_SEQ])
      else $error("input overrun not flagged");
   a_frame_count: assert property (rd_mode && ev_i.block_end && pk_cnt != 3'h0
                                   |=> err[E_FCNT] ##2 ext_int_o)
      else $error("odd frame count not reported");
   a_limit_seen: assert property (state == ST_RUN && ev_i.limit && tcsi_lim(op_o)
                                  |=> err[E_LIM] ##2 ext_int_o)
      else $error("tape limit not reported");
   a_clean_done: assert property (state == ST_REPORT && err == ERR_NONE && irq
                                  |=> s_status(SC_DONE))
      else $error("normal completion not reported as 40");
   a_forward_only: assert property ((wr_char_valid_o || $rose(in_req_o)) |-> $past(fwd_o))
      else $error("data moved while tape not forward");
   a_first_char: assert property (wr_mode && ev_i.wr_slot && wfull && !(out_ack_i && out_req_o)
                                  |=> wr_char_valid_o && wr_char_o == $past(wbuf[29:24]))
      else $error("character order wrong");
   a_search_hit: assert property (rd_mode && op_o == OP_SEARCH && pk_valid && first_word
                                  && !found && pk_word == ident && !rd_busy
                                  |=> in_req_o && in_word_o == $past(ident))
      else $error("search match not read");
endmodule : tcsi_channel_if
`default_nettype wire

// file: hw/tcsi_pkg.sv
`default_nettype none
package tcsi_pkg;
   // word and character layout
   localparam int WORD_W = 30;
   localparam int CHAR_W = 6;
   localparam int CHARS = 5;
   localparam int UNITS = 16;
   localparam int CODE_LSB = 24;
   localparam int CODE_W = 6;
   // octal xyz digit 3 bit 0 marks the with-interrupt variant
   localparam logic [11:0] FN_IRQ_MASK = 12'h200;
   // function codes with the interrupt bit cleared
   localparam logic [11:0] FN_RD_HI = 12'h890;
   localparam logic [11:0] FN_RD_LO = 12'h8d0;
   localparam logic [11:0] FN_RD_HI_T = 12'h891;
   localparam logic [11:0] FN_RD_LO_T = 12'h8d1;
   localparam logic [11:0] FN_SR_HI = 12'h990;
   localparam logic [11:0] FN_SR_LO = 12'h9d0;
   localparam logic [11:0] FN_SR_HI_T = 12'h991;
   localparam logic [11:0] FN_SR_LO_T = 12'h9d1;
   localparam logic [11:0] FN_WR_HI = 12'h090;
   localparam logic [11:0] FN_WR_LO = 12'h0d0;
   localparam logic [11:0] FN_WR_HI_T = 12'h091;
   localparam logic [11:0] FN_WR_LO_T = 12'h0d1;
   localparam logic [11:0] FN_WM_HI = 12'h0b0;
   localparam logic [11:0] FN_WM_LO = 12'h0f0;
   localparam logic [11:0] FN_WM_HI_T = 12'h0b1;
   localparam logic [11:0] FN_WM_LO_T = 12'h0f1;
   localparam logic [11:0] FN_REW = 12'h408;
   localparam logic [11:0] FN_REW_LK = 12'h448;
   localparam logic [11:0] FN_BOOT = 12'h800;
   localparam logic [11:0] FN_BSP_BLK = 12'h418;
   localparam logic [11:0] FN_BSP_FILE = 12'h458;
   localparam logic [11:0] FN_ERASE = 12'h018;
   localparam logic [11:0] FN_TERM = 12'h4c0;
   // status codes, octal values written in hex
   localparam logic [5:0] SC_FN = 6'h1c;    // 34 octal
   localparam logic [5:0] SC_REW = 6'h14;   // 24
   localparam logic [5:0] SC_EOF = 6'h2c;   // 54
   localparam logic [5:0] SC_SEQ = 6'h28;   // 50
   localparam logic [5:0] SC_ILK = 6'h3c;   // 74
   localparam logic [5:0] SC_PAR = 6'h24;   // 44
   localparam logic [5:0] SC_FCNT = 6'h38;  // 70
   localparam logic [5:0] SC_LIM = 6'h30;   // 60
   localparam logic [5:0] SC_CCNT = 6'h18;  // 30
   localparam logic [5:0] SC_CSEQ = 6'h10;  // 20
   localparam logic [5:0] SC_DONE = 6'h20;  // 40
   // error bit positions, lowest index wins
   localparam int E_FN = 0;
   localparam int E_REW = 1;
   localparam int E_EOF = 2;
   localparam int E_SEQ = 3;
   localparam int E_ILK = 4;
   localparam int E_PAR = 5;
   localparam int E_FCNT = 6;
   localparam int E_LIM = 7;
   localparam int E_CCNT = 8;
   localparam int E_CSEQ = 9;
   localparam int NERR = 10;
   localparam logic [NERR-1:0] ERR_NONE = 10'h000;
   localparam logic [NERR-1:0] ERR_DEFER = 10'h020; // parity waits for block end

   typedef enum logic [3:0] {
      OP_READ = 4'h0, OP_WRITE = 4'h1, OP_SEARCH = 4'h2, OP_REW = 4'h3, OP_REW_LK = 4'h4,
      OP_BOOT = 4'h5, OP_BSP_BLK = 4'h6, OP_BSP_FILE = 4'h7, OP_ERASE = 4'h8, OP_TERM = 4'h9
   } tcsi_op_t;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001, ST_IDENT = 4'b0010, ST_RUN = 4'b0100, ST_REPORT = 4'b1000
   } tcsi_state_t;

   typedef struct packed {
      logic valid;
      tcsi_op_t op;
      logic irq;
   } tcsi_dec_t;

   // events from the tape side, one cycle each
   typedef struct packed {
      logic frame_valid;
      logic [CHAR_W-1:0] frame;
      logic par_err;
      logic block_end;
      logic tape_mark;
      logic limit;
      logic echo_err;
      logic cmp_err;
      logic cc_err;
      logic wr_slot;
      logic done;
   } tcsi_tape_ev_t;

   function automatic tcsi_dec_t tcsi_decode(input logic [11:0] code);
      tcsi_dec_t d;
      d.valid = 1'b1;
      d.irq = |(code & FN_IRQ_MASK);
      unique case (code & ~FN_IRQ_MASK)
         FN_RD_HI, FN_RD_LO, FN_RD_HI_T, FN_RD_LO_T: d.op = OP_READ;
         FN_SR_HI, FN_SR_LO, FN_SR_HI_T, FN_SR_LO_T: d.op = OP_SEARCH;
         FN_WR_HI, FN_WR_LO, FN_WR_HI_T, FN_WR_LO_T: d.op = OP_WRITE;
         FN_WM_HI, FN_WM_LO, FN_WM_HI_T, FN_WM_LO_T: d.op = OP_WRITE;
         FN_REW: d.op = OP_REW;
         FN_REW_LK: d.op = OP_REW_LK;
         FN_BOOT: d.op = OP_BOOT;
         FN_BSP_BLK: d.op = OP_BSP_BLK;
         FN_BSP_FILE: d.op = OP_BSP_FILE;
         FN_ERASE: d.op = OP_ERASE;
         FN_TERM: d.op = OP_TERM;
         default: begin
            d.op = OP_READ;
            d.valid = 1'b0;
         end
      endcase
      return d;
   endfunction : tcsi_decode

   function automatic logic [5:0] tcsi_pick(input logic [NERR-1:0] e);
      logic [5:0] c;
      c = SC_DONE;
      if (e[E_CSEQ]) c = SC_CSEQ;
      if (e[E_CCNT]) c = SC_CCNT;
      if (e[E_LIM]) c = SC_LIM;
      if (e[E_FCNT]) c = SC_FCNT;
      if (e[E_PAR]) c = SC_PAR;
      if (e[E_ILK]) c = SC_ILK;
      if (e[E_SEQ]) c = SC_SEQ;
      if (e[E_EOF]) c = SC_EOF;
      if (e[E_REW]) c = SC_REW;
      if (e[E_FN]) c = SC_FN;
      return c;
   endfunction : tcsi_pick

   function automatic logic tcsi_fwd(input tcsi_op_t op);
      return op inside {OP_READ, OP_WRITE, OP_SEARCH, OP_BOOT, OP_ERASE};
   endfunction : tcsi_fwd

   function automatic logic tcsi_lim(input tcsi_op_t op);
      return op inside {OP_READ, OP_WRITE, OP_SEARCH, OP_ERASE, OP_BSP_BLK, OP_BSP_FILE};
   endfunction : tcsi_lim
endpackage : tcsi_pkg
`default_nettype wire

// file: hw/tcsi_char_pack.sv
`default_nettype none
module tcsi_char_pack #(
   parameter int CHAR_W = 6,
   parameter int CHARS = 5,
   parameter int CNT_W = 3
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic clr_i,
   input wire logic ch_valid_i,
   input wire logic [CHAR_W-1:0] ch_i,
   output logic [CHAR_W*CHARS-1:0] word_o,
   output logic word_valid_o,
   output logic [CNT_W-1:0] cnt_o
);
   localparam logic [CNT_W-1:0] LAST = CNT_W'(CHARS - 1);

   // first character lands in the top slot after all shifts
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         word_o <= '0;
         cnt_o <= '0;
         word_valid_o <= 1'b0;
      end else begin
         word_valid_o <= 1'b0;
         if (clr_i) begin
            cnt_o <= '0;
         end else if (ch_valid_i) begin
            word_o <= {word_o[CHAR_W*(CHARS-1)-1:0], ch_i};
            if (cnt_o == LAST) begin
               cnt_o <= '0;
               word_valid_o <= 1'b1;
            end else begin
               cnt_o <= cnt_o + 1'b1;
            end
         end
      end
   end
endmodule : tcsi_char_pack
`default_nettype wire

// file: verification/tcsi_cpu_model.sv
`default_nettype none
module tcsi_cpu_model
   import tcsi_pkg::*;
(
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic in_req_i,
   input wire logic out_req_i,
   input wire logic stall_i,
   input wire logic tx_en_i,
   input wire logic id_go_i,
   input wire logic [WORD_W-1:0] tx_word_i,
   output logic in_ack_o,
   output logic out_ack_o,
   output logic ext_fn_o,
   output logic [WORD_W-1:0] out_word_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // one-cycle acknowledges; stall models a processor that is late
   always @(negedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         in_ack_o <= 1'b0;
         out_ack_o <= 1'b0;
         ext_fn_o <= 1'b0;
      end else begin
         in_ack_o <= in_req_i && !in_ack_o && !stall_i;
         out_ack_o <= out_req_i && tx_en_i && !out_ack_o && !stall_i;
         ext_fn_o <= id_go_i;
      end
   end
   // released bus shows the inverse so a stale word cannot pass
   assign out_word_o = (out_ack_o || ext_fn_o) ? tx_word_i : ~tx_word_i;
endmodule : tcsi_cpu_model
`default_nettype wire

// file: verification/tb_top.sv
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import tcsi_pkg::*;
   logic clk, nrst, fn_valid, eob, stall, tx_en, id_go, ext_fn, out_ack, in_ack;
   logic ext_int, in_req, out_req, wr_v, run, fwd;
   logic [11:0] fn_code;
   logic [15:0] unit_sel, u_pres, u_ring, u_ilk, u_rew, unit;
   logic [29:0] tx_word, out_word, sw, in_word, sw_last;
   logic [5:0] wr_ch;
   tcsi_tape_ev_t ev;
   tcsi_op_t op;
   // n_base marks the interrupt count when a function is issued, so early reports count
   int err_total, n_tests, n_int, n_base;
   logic [29:0] rq[$];
   logic [5:0] wq[$];

   tcsi_channel_if uut (.clk_i(clk), .nrst_i(nrst), .fn_valid_i(fn_valid), .fn_code_i(fn_code),
      .unit_sel_i(unit_sel), .ext_fn_i(ext_fn), .out_word_i(out_word), .out_ack_i(out_ack),
      .in_ack_i(in_ack), .eob_i(eob), .unit_present_i(u_pres), .unit_ring_i(u_ring),
      .unit_ilk_i(u_ilk), .unit_rewinding_i(u_rew), .ev_i(ev), .status_word_o(sw),
      .ext_int_o(ext_int), .in_word_o(in_word), .in_req_o(in_req), .out_req_o(out_req),
      .wr_char_o(wr_ch), .wr_char_valid_o(wr_v), .unit_o(unit), .op_o(op), .run_o(run),
      .fwd_o(fwd));
   tcsi_cpu_model cpu (.clk_i(clk), .nrst_i(nrst), .in_req_i(in_req), .out_req_i(out_req),
      .stall_i(stall), .tx_en_i(tx_en), .id_go_i(id_go), .tx_word_i(tx_word),
      .in_ack_o(in_ack), .out_ack_o(out_ack), .ext_fn_o(ext_fn), .out_word_o(out_word));

   always #20 clk = ~clk;
   // record status words, words handed over and characters to tape
   always @(posedge clk) begin
      if (ext_int === 1'b1) begin
         sw_last = sw;
         n_int++;
      end
      if (in_req === 1'b1 && in_ack === 1'b1) rq.push_back(in_word);
      if (wr_v === 1'b1) wq.push_back(wr_ch);
   end

   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : stop_test

   task automatic chk(input logic [29:0] got, input logic [29:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic fn(input logic [11:0] code, input logic [15:0] sel);
      n_base = n_int;
      @(negedge clk);
      fn_valid <= 1'b1;
      fn_code <= code;
      unit_sel <= sel;
      @(negedge clk);
      fn_valid <= 1'b0;
   endtask : fn

   task automatic put(input tcsi_tape_ev_t e);
      @(negedge clk);
      ev <= e;
   endtask : put

   // exactly one status word, code in the top six bits only
   task automatic wstat(input logic [5:0] exp);
      for (int i = 0; i < 300 && n_int == n_base; i++) @(posedge clk);
      chk(30'(n_int - n_base), 30'h1);
      chk(sw_last, {exp, 24'h0});
      repeat (4) @(negedge clk);
   endtask : wstat

   task automatic waitrun(input logic dir, input tcsi_op_t op_exp);
      for (int i = 0; i < 8 && run !== 1'b1; i++) @(posedge clk);
      #1 chk(30'(fwd), 30'(dir));
      chk(30'(op), 30'(op_exp));
      chk(30'(unit), 30'(unit_sel));
   endtask : waitrun

   task automatic rd(input logic [5:0] exp, input tcsi_tape_ev_t f, input int nfr, input logic st);
      logic [29:0] w;
      tcsi_tape_ev_t e;
      rq = {};
      stall <= st;
      fn(FN_RD_HI | FN_IRQ_MASK, 16'h0001);
      waitrun(1'b1, OP_READ);
      for (int i = 0; i < nfr; i++) begin
         e = '0;
         e.frame_valid = 1'b1;
         e.frame = 6'h11 + 6'(i);
         if (i < 5) w = {w[23:0], e.frame};
         put(i == 0 ? (e | f) : e);
      end
      put('0);
      put(16'h0080);
      put('0);
      wstat(exp);
      stall <= 1'b0;
      // let a stalled word drain before the next scenario clears its queue
      repeat (3) @(negedge clk);
      if (nfr == 5 && (exp == SC_DONE || exp == SC_PAR)) chk(rq[0], w);
   endtask : rd

   task automatic srch;
      logic [29:0] id;
      id = 30'h2a5c3e91;
      rq = {};
      tx_word <= id;
      fn(FN_SR_LO | FN_IRQ_MASK, 16'h0001);
      id_go <= 1'b1;
      @(negedge clk);
      id_go <= 1'b0;
      repeat (3) @(negedge clk);
      // first block differs in its last character and must be skipped
      for (int b = 0; b < 2; b++) begin
         for (int i = 0; i < 5; i++) put(frm(id[29-6*i -: 6] ^ 6'((b == 0) && (i == 4))));
         put('0);
         repeat (4) @(negedge clk);
         if (b == 0) chk(30'(rq.size()), 30'h0);
         put(16'h0080);
         put('0);
      end
      wstat(SC_DONE);
      chk(rq[0], id);
   endtask : srch

   function automatic tcsi_tape_ev_t frm(input logic [5:0] c);
      frm = '0;
      frm.frame_valid = 1'b1;
      frm.frame = c;
   endfunction : frm

   task automatic wr(input logic [29:0] w, input int nslot, input logic [5:0] exp,
                     input tcsi_tape_ev_t f);
      wq = {};
      tx_word <= w;
      tx_en <= 1'b1;
      fn(FN_WR_HI | FN_IRQ_MASK, 16'h0001);
      for (int i = 0; i < 20 && out_ack !== 1'b1; i++) @(posedge clk);
      @(negedge clk);
      tx_en <= 1'b0;
      for (int i = 0; i < nslot; i++) begin
         put(i == 1 ? (16'h0002 | f) : 16'h0002);
         put('0);
      end
      @(negedge clk);
      eob <= 1'b1;
      @(negedge clk);
      eob <= 1'b0;
      put(16'h0001);
      put('0);
      wstat(exp);
      if (exp == SC_DONE) begin
         chk(30'(wq.size()), 30'h5);
         for (int i = 0; i < 5; i++) chk(30'(wq[i]), 30'(w[29-6*i -: 6]));
      end
   endtask : wr

   initial begin
      clk = 1'b0;
      nrst = 1'b0;
      {fn_valid, eob, stall, tx_en, id_go} = '0;
      fn_code = 12'h0;
      unit_sel = 16'h0;
      u_pres = 16'h00ff;
      u_ring = 16'h0001;
      u_ilk = 16'h0004;
      u_rew = 16'h0008;
      tx_word = 30'h0;
      ev = '0;
      repeat (20) @(posedge clk);
      @(negedge clk);
      nrst <= 1'b1;
      // refused functions and unit faults
      fn(12'h777, 16'h0001);
      wstat(SC_FN);
      fn(FN_RD_HI, 16'h0000);
      wstat(SC_FN);
      fn(FN_RD_HI, 16'h0003);
      wstat(SC_FN);
      fn(FN_RD_HI, 16'h8000);
      wstat(SC_ILK);
      fn(FN_RD_HI, 16'h0004);
      wstat(SC_ILK);
      fn(FN_WR_HI, 16'h0002);
      wstat(SC_ILK);
      fn(FN_RD_HI, 16'h0008);
      wstat(SC_REW);
      rd(SC_DONE, '0, 5, 1'b0);
      rd(SC_PAR, 16'h0100, 5, 1'b0);
      rd(SC_EOF, 16'h0040, 5, 1'b0);
      rd(SC_LIM, 16'h0020, 5, 1'b0);
      rd(SC_CCNT, 16'h0004, 5, 1'b0);
      rd(SC_FCNT, '0, 3, 1'b0);
      rd(SC_EOF, 16'h0140, 5, 1'b0);
      rd(SC_SEQ, '0, 10, 1'b1);
      srch();
      wr(30'h12345678, 5, SC_DONE, '0);
      wr(30'h00345678, 5, SC_FN, '0);
      wr(30'h12345678, 2, SC_CSEQ, '0);
      wr(30'h12345678, 5, SC_EOF, 16'h0010);
      wr(30'h12345678, 5, SC_PAR, 16'h0008);
      fn(FN_TERM | FN_IRQ_MASK, 16'h0001);
      wstat(SC_DONE);
      fn(FN_ERASE | FN_IRQ_MASK, 16'h0001);
      waitrun(1'b1, OP_ERASE);
      put(16'h0020);
      put('0);
      wstat(SC_LIM);
      fn(FN_BSP_BLK | FN_IRQ_MASK, 16'h0001);
      waitrun(1'b0, OP_BSP_BLK);
      put(16'h0001);
      put('0);
      wstat(SC_DONE);
      stop_test();
   end

   // cut a hang short well beyond the expected run length
   initial begin
      #(40 * 30000);
      err_total++;
      stop_test();
   end
endmodule : tb_top
`default_nettype wire
